// File: logic/sspx_exec.sv
// Execution unit for subtract, shift, pointer load and stop instructions.
// Assumes decoded instruction bytes from fetch logic on the same clock.
`timescale 1ns/1ps
`include "sspx_defs.svh"
module sspx_exec
    import sspx_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction from decode
    input wire sspx_inst_type inst_i,
    input wire logic inst_valid_i,
    output logic inst_ready_o,
    // Execution results
    output logic done_o,
    output logic [7:0] result_o,
    output sspx_flags_type flags_o,
    output logic stopped_o,
    // External interrupt pin, asynchronous
    input wire logic wake_irq_i,
    // AXI4-Lite write
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] rf [0:255];
    logic [7:0] working_pointer_zero;
    logic [7:0] working_pointer_one;
    logic [2:0] cnt;
    logic wake_s1, wake_s2, wake_s3, wake_lvl;
    logic aw_have, w_have;
    logic [11:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic acc, bus_wr;
    sspx_op_type cls;
    logic [7:0] dst_addr, dst_val, src_val, next_result;
    logic [8:0] diff9;
    logic [4:0] nib5;
    logic cin, wr_dst;
    sspx_flags_type next_flags;
    logic [2:0] next_cnt;
    logic next_stopped;

    localparam logic [11:0] RP0_BYTE = {2'h0, `SSPX_RP0_ADDR, 2'h0};
    localparam logic [11:0] RP1_BYTE = {2'h0, `SSPX_RP1_ADDR, 2'h0};

    function automatic sspx_op_type op_class(input logic [7:0] opc);
        if ((opc[3:0] >= `SSPX_MODE_RR) && (opc[3:0] <= `SSPX_MODE_GIM)) begin
            if (opc[7:4] == `SSPX_OPHI_SBC) return OP_SBC;
            if (opc[7:4] == `SSPX_OPHI_SUB) return OP_SUB;
        end
        case (opc)
            `SSPX_OPC_SRA_R, `SSPX_OPC_SRA_IR: return OP_SRA;
            `SSPX_OPC_SRP: return OP_SRP;
            `SSPX_OPC_SCF: return OP_SCF;
            `SSPX_OPC_STOP: return OP_STOP;
            default: return OP_NONE;
        endcase
    endfunction

    // Working register n: low eight through pointer zero, high eight through one
    function automatic logic [7:0] wr_addr(input logic [3:0] n);
        return n[3] ? {working_pointer_one[7:3], n[2:0]}
                    : {working_pointer_zero[7:3], n[2:0]};
    endfunction

    // Pointers are read back at their register addresses
    function automatic logic [7:0] rd_reg(input logic [7:0] a);
        if (a == `SSPX_RP0_ADDR) return working_pointer_zero; // [RQ12]
        if (a == `SSPX_RP1_ADDR) return working_pointer_one; // [RQ12]
        return rf[a];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Operand fetch and arithmetic
    assign acc = inst_valid_i && inst_ready_o;
    assign cls = op_class(inst_i.opcode);

    always_comb begin
        dst_addr = 8'h00;
        src_val = 8'h00;
        if (cls == OP_SRA) begin
            // [RQ9] [RQ20]
            dst_addr = inst_i.opcode[0] ? rd_reg(inst_i.op1) : inst_i.op1;
        end else begin
            case (inst_i.opcode[3:0]) // [RQ5] [RQ17]
                `SSPX_MODE_RR: begin
                    dst_addr = wr_addr(inst_i.op1[7:4]);
                    src_val = rd_reg(wr_addr(inst_i.op1[3:0]));
                end
                `SSPX_MODE_RIR: begin
                    dst_addr = wr_addr(inst_i.op1[7:4]);
                    src_val = rd_reg(rd_reg(wr_addr(inst_i.op1[3:0]))); // [RQ20]
                end
                `SSPX_MODE_GG: begin
                    dst_addr = inst_i.op2;
                    src_val = rd_reg(inst_i.op1);
                end
                `SSPX_MODE_GIG: begin
                    dst_addr = inst_i.op2;
                    src_val = rd_reg(rd_reg(inst_i.op1)); // [RQ20]
                end
                `SSPX_MODE_GIM: begin
                    dst_addr = inst_i.op1;
                    src_val = inst_i.op2;
                end
                default: begin
                    dst_addr = 8'h00;
                    src_val = 8'h00;
                end
            endcase
        end
        dst_val = rd_reg(dst_addr);
    end

    // Plain subtract ignores carry
    assign cin = (cls == OP_SBC) ? flags_o.c : 1'b0; // [RQ1] [RQ17]
    assign diff9 = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, cin};
    assign nib5 = {1'b0, dst_val[3:0]} - {1'b0, src_val[3:0]} - {4'h0, cin};

    always_comb begin
        next_result = dst_val;
        next_flags = flags_o;
        wr_dst = 1'b0;
        case (cls)
            OP_SBC, OP_SUB: begin
                next_result = diff9[7:0]; // [RQ1] [RQ17]
                wr_dst = 1'b1;
                next_flags.c = diff9[8]; // [RQ2] [RQ18]
                next_flags.z = (diff9[7:0] == 8'h00); // [RQ3] [RQ18]
                next_flags.s = diff9[7];
                next_flags.v = (dst_val[7] ^ src_val[7]) & (diff9[7] == src_val[7]);
                next_flags.d = 1'b1; // [RQ4] [RQ19]
                next_flags.h = nib5[4];
            end
            OP_SCF: begin
                next_flags.c = 1'b1; // [RQ6]
            end
            OP_SRA: begin
                next_result = {dst_val[7], dst_val[7:1]}; // [RQ7]
                wr_dst = 1'b1;
                next_flags.c = dst_val[0]; // [RQ8]
                next_flags.z = (next_result == 8'h00);
                next_flags.s = dst_val[7];
                next_flags.v = 1'b0;
            end
            default: begin
                next_result = dst_val;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file has no reset so stop mode and warm reset keep it [RQ14]
    always_ff @(posedge clk_i) begin
        if (acc && wr_dst && dst_addr != `SSPX_RP0_ADDR && dst_addr != `SSPX_RP1_ADDR) begin
            rf[dst_addr] <= next_result;
        end
    end

    // Instruction writes beat a bus write in the same cycle
    assign bus_wr = aw_have && w_have && !s_axi_bvalid_o && w_lane0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            working_pointer_zero <= `SSPX_RP0_RST;
            working_pointer_one <= `SSPX_RP1_RST;
        end else if (acc && cls == OP_SRP) begin
            case (inst_i.op1[1:0]) // [RQ10]
                `SSPX_SEL_ZERO: working_pointer_zero[7:3] <= inst_i.op1[7:3];
                `SSPX_SEL_ONE: working_pointer_one[7:3] <= inst_i.op1[7:3];
                `SSPX_SEL_BOTH: begin
                    working_pointer_zero[7:3] <= {inst_i.op1[7:4], 1'b0}; // [RQ11]
                    working_pointer_one[7:3] <= {inst_i.op1[7:4], 1'b1};
                end
                default: working_pointer_zero <= working_pointer_zero;
            endcase
        end else if (acc && wr_dst && dst_addr == `SSPX_RP0_ADDR) begin
            working_pointer_zero <= next_result; // [RQ12]
        end else if (acc && wr_dst && dst_addr == `SSPX_RP1_ADDR) begin
            working_pointer_one <= next_result; // [RQ12]
        end else if (bus_wr && aw_addr == RP0_BYTE) begin
            working_pointer_zero <= w_data;
        end else if (bus_wr && aw_addr == RP1_BYTE) begin
            working_pointer_one <= w_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= `SSPX_FLAGS_RST;
        end else if (acc) begin
            flags_o <= next_flags;
        end else if (bus_wr && aw_addr == `SSPX_OFS_FLAGS) begin
            flags_o <= w_data[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= 8'h00;
        end else if (acc) begin
            result_o <= next_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle timing and stop mode
    always_comb begin
        next_cnt = cnt;
        if (acc) begin
            next_cnt = ((cls == OP_SBC || cls == OP_SUB) && inst_i.opcode[3:0] != `SSPX_MODE_RR)
                ? `SSPX_CYC_LONG - 3'h1 : `SSPX_CYC_SHORT - 3'h1; // [RQ5] [RQ6] [RQ9]
        end else if (cnt != 3'h0) begin
            next_cnt = cnt - 3'h1;
        end
        next_stopped = stopped_o;
        if (acc && cls == OP_STOP) begin
            next_stopped = 1'b1; // [RQ13]
        end else if (stopped_o && wake_lvl) begin
            next_stopped = 1'b0; // [RQ15]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 3'h0;
            stopped_o <= 1'b0; // [RQ15]
            inst_ready_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            stopped_o <= next_stopped;
            inst_ready_o <= (next_cnt == 3'h0) && !next_stopped; // [RQ13]
            done_o <= (cnt == 3'h1);
        end
    end

    // Three-stage pin filter; the first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
            wake_lvl <= 1'b0;
        end else begin
            wake_s1 <= wake_irq_i;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
            if (wake_s2 == wake_s3) begin
                wake_lvl <= wake_s3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, one write and one read in flight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SSPX_RESP_OKAY;
        end else begin
            s_axi_awready_o <= !aw_have && !(s_axi_awvalid_i && s_axi_awready_o);
            s_axi_wready_o <= !w_have && !(s_axi_wvalid_i && s_axi_wready_o);
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
            end
            if (aw_have && w_have && !s_axi_bvalid_o) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr == `SSPX_OFS_FLAGS || aw_addr == RP0_BYTE
                    || aw_addr == RP1_BYTE) ? `SSPX_RESP_OKAY : `SSPX_RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `SSPX_RESP_OKAY;
        end else if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `SSPX_RESP_OKAY;
            case (s_axi_araddr_i)
                `SSPX_OFS_FLAGS: s_axi_rdata_o <= {26'h0, flags_o};
                `SSPX_OFS_STATUS: s_axi_rdata_o <= {30'h0, !inst_ready_o, stopped_o};
                RP0_BYTE: s_axi_rdata_o <= {24'h000000, working_pointer_zero};
                RP1_BYTE: s_axi_rdata_o <= {24'h000000, working_pointer_one};
                default: begin
                    s_axi_rdata_o <= 32'h00000000;
                    s_axi_rresp_o <= `SSPX_RESP_SLVERR;
                end
            endcase
        end else begin
            s_axi_arready_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence busy_long;
        !inst_ready_o [*5] ##1 inst_ready_o;
    endsequence
    sequence busy_short;
        !inst_ready_o [*3] ##1 inst_ready_o;
    endsequence

    chk_sbc_value: assert property (acc && cls == OP_SBC |=> // [RQ1]
        result_o == $past(dst_val) - $past(src_val) - {7'h00, $past(flags_o.c)})
        else $error("borrow subtract result wrong");
    chk_sbc_carry: assert property (acc && cls == OP_SBC |=> // [RQ2]
        flags_o.c == ({1'b0, $past(dst_val)} < {1'b0, $past(src_val)} + {8'h00, $past(flags_o.c)}))
        else $error("borrow subtract carry wrong");
    chk_sub_zero_sign: assert property (acc && (cls == OP_SUB || cls == OP_SBC) |=> // [RQ3]
        flags_o.z == (result_o == 8'h00) && flags_o.s == result_o[7])
        else $error("subtract zero or sign wrong");
    chk_sub_dec_half: assert property (acc && (cls == OP_SUB || cls == OP_SBC) |=> // [RQ4]
        flags_o.d && flags_o.h == ({1'b0, $past(dst_val[3:0])} <
        {1'b0, $past(src_val[3:0])} + {4'h0, $past(cin)}))
        else $error("subtract decimal or half flag wrong");
    chk_long_timing: assert property (acc && next_cnt == `SSPX_CYC_LONG - 3'h1 // [RQ5]
        && cls != OP_STOP |=> busy_long)
        else $error("six cycle instruction timing wrong");
    chk_scf_only: assert property (acc && cls == OP_SCF |=> flags_o.c // [RQ6]
        && flags_o[4:0] == $past(flags_o[4:0]) ##0 busy_short)
        else $error("set carry changed other flags");
    chk_sra_value: assert property (acc && cls == OP_SRA |=> // [RQ7]
        result_o == {$past(dst_val[7]), $past(dst_val[7:1])} && flags_o.c == $past(dst_val[0]))
        else $error("arithmetic shift result wrong");
    chk_sra_flags: assert property (acc && cls == OP_SRA |=> !flags_o.v // [RQ8]
        && flags_o.d == $past(flags_o.d) && flags_o.h == $past(flags_o.h))
        else $error("arithmetic shift flags wrong");
    chk_ptr_both: assert property (acc && cls == OP_SRP && inst_i.op1[1:0] == 2'h0 |=> // [RQ11]
        working_pointer_zero[7:3] == {$past(inst_i.op1[7:4]), 1'b0}
        && working_pointer_one[7:3] == {$past(inst_i.op1[7:4]), 1'b1})
        else $error("dual pointer load wrong");
    chk_ptr_single: assert property (acc && cls == OP_SRP && inst_i.op1[1:0] == 2'h2 |=> // [RQ10]
        working_pointer_zero[7:3] == $past(inst_i.op1[7:3])
        && working_pointer_one == $past(working_pointer_one))
        else $error("pointer zero load wrong");
    chk_stop_entry: assert property (acc && cls == OP_STOP |=> stopped_o && !inst_ready_o) // [RQ13]
        else $error("stop did not halt");
    chk_stop_hold: assert property (stopped_o && !wake_lvl |=> stopped_o // [RQ15]
        && flags_o == $past(flags_o))
        else $error("stop left without wake");

endmodule

// File: logic/sspx_defs.svh
// Constants of the subtract, shift, pointer and stop execution block.
// Assumes inclusion by the package, the execution module and the bench.
// How it works
// RQ1: Borrow subtract: destination minus source minus carry.
// RQ2: Borrow subtract sets carry on borrow.
// RQ3: Borrow subtract: zero, sign, signed overflow flags.
// RQ4: Borrow subtract: decimal flag one, half means borrow.
// RQ5: Borrow subtract opcodes 32-36, cycles four or six.
// RQ6: Set-carry forces carry, four cycles, nothing else.
// RQ7: Shift right keeps and copies sign bit.
// RQ8: Shift: carry old bit0, zero, sign, overflow cleared.
// RQ9: Shift opcodes D0 direct, D1 indirect, four cycles.
// RQ10: Pointer load: low two immediate bits choose target.
// RQ11: Both pointers: high nibble, bit3 zero and one.
// RQ12: Pointers live at register addresses D6 and D7.
// RQ13: Stop opcode halts execution, enters stop mode.
// RQ14: Stop mode keeps all register contents.
// RQ15: Only reset or external interrupt leaves stop.
// RQ16: Waking by reset holds reset through oscillator settling; the block adds no hold and leaves reset on the first edge with rst_i low.
// RQ17: Plain subtract ignores carry, opcodes 22-26.
// RQ18: Plain subtract: carry, zero, sign, overflow flags.
// RQ19: Plain subtract: decimal flag one, half means borrow.
// RQ20: Indirect forms use register contents as operand address.
`ifndef SSPX_DEFS_SVH
`define SSPX_DEFS_SVH

// Opcodes
`define SSPX_OPHI_SBC 4'h3
`define SSPX_OPHI_SUB 4'h2
`define SSPX_MODE_RR 4'h2
`define SSPX_MODE_RIR 4'h3
`define SSPX_MODE_GG 4'h4
`define SSPX_MODE_GIG 4'h5
`define SSPX_MODE_GIM 4'h6
`define SSPX_OPC_SRA_R 8'hD0
`define SSPX_OPC_SRA_IR 8'hD1
`define SSPX_OPC_SRP 8'h31
`define SSPX_OPC_SCF 8'hDF
`define SSPX_OPC_STOP 8'h7F
`define SSPX_SEL_BOTH 2'h0
`define SSPX_SEL_ONE 2'h1
`define SSPX_SEL_ZERO 2'h2

// Cycle counts
`define SSPX_CYC_SHORT 3'h4
`define SSPX_CYC_LONG 3'h6

// Register file locations and reset values
`define SSPX_RP0_ADDR 8'hD6
`define SSPX_RP1_ADDR 8'hD7
`define SSPX_RP0_RST 8'h00
`define SSPX_RP1_RST 8'h08
`define SSPX_FLAGS_RST 6'h00

// Bus offsets
`define SSPX_OFS_FLAGS 12'h000
`define SSPX_OFS_STATUS 12'h004
`define SSPX_RESP_OKAY 2'h0
`define SSPX_RESP_SLVERR 2'h2

`endif

// File: logic/sspx_pkg.sv
// Types shared by the execution block and its surroundings.
// Assumes the constants header is on the include path.
`include "sspx_defs.svh"
package sspx_pkg;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] op1;
        logic [7:0] op2;
    } sspx_inst_type;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } sspx_flags_type;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SBC,
        OP_SUB,
        OP_SCF,
        OP_SRA,
        OP_SRP,
        OP_STOP
    } sspx_op_type;

endpackage

// File: bench/sspx_fetch_model.sv
// Fetch-side model: offers one decoded instruction at a time to the execution block.
// Assumes one clock shared with the block and its valid/ready instruction handshake.
`timescale 1ns/1ps
module sspx_fetch_model
    import sspx_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench command
    input wire logic go_i,
    input wire sspx_inst_type cmd_i,
    output logic taken_o,
    // Towards the execution block
    output sspx_inst_type inst_o,
    output logic valid_o,
    input wire logic ready_i
);
    initial begin
        valid_o = 1'b0;
        taken_o = 1'b0;
        inst_o = 24'hA5C3E1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Offer held until the edge that takes it, then released
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            taken_o <= 1'b0;
        end else begin
            taken_o <= valid_o && ready_i;
            if (valid_o && ready_i) begin
                valid_o <= 1'b0;
                // Released bytes flip so the block cannot lean on a stale value
                inst_o <= ~inst_o;
            end else if (go_i && !valid_o) begin
                valid_o <= 1'b1;
                inst_o <= cmd_i;
            end
        end
    end
endmodule

// File: bench/tb_subtract_shift_pointer_exec.sv
// Self-checking bench of the subtract, shift, pointer and stop execution block.
// Assumes the block's package and constants header, and the fetch-side model.
`timescale 1ns/1ps
`include "sspx_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_subtract_shift_pointer_exec
    import sspx_pkg::*;
;
    localparam logic [11:0] A_P0 = {2'h0, `SSPX_RP0_ADDR, 2'h0};
    localparam logic [11:0] A_P1 = {2'h0, `SSPX_RP1_ADDR, 2'h0};
    localparam logic [1:0] OK = `SSPX_RESP_OKAY;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0;
    logic wake = 1'b0;
    sspx_inst_type cmd = 24'h000000;
    sspx_inst_type inst;
    sspx_flags_type flg;
    logic taken, valid, ready, done, stopped;
    logic [7:0] res;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int n_compared = 0;

    always #20 clk_i = ~clk_i;

    sspx_fetch_model fetch (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd),
        .taken_o(taken), .inst_o(inst), .valid_o(valid), .ready_i(ready));

    sspx_exec dut (.clk_i(clk_i), .rst_i(rst_i), .inst_i(inst), .inst_valid_i(valid),
        .inst_ready_o(ready), .done_o(done), .result_o(res), .flags_o(flg),
        .stopped_o(stopped), .wake_irq_i(wake),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks: each channel held until its own ready is sampled
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        `CHK("bvalid", 1'b1, bvalid)
        `CHK("bresp", er, bresp)
    endtask

    task automatic bus_rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rresp", er, rresp)
        `CHK("rdata", {24'h000000, e}, rdata)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction tasks
    task automatic offer(input logic [23:0] v);
        @(posedge clk_i);
        cmd <= v;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
    endtask

    task automatic wait_flag(input bit want_done, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(want_done ? done === 1'b1 : taken === 1'b1) && n < 200);
    endtask

    // Fields: opcode, op1, op2, preset ptr0, ptr1, flags, expected ptr0, ptr1, flags
    task automatic run(input logic [71:0] v);
        logic [7:0] op, a, b, p0, p1, fl, e0, e1, ef;
        int n, cyc;
        {op, a, b, p0, p1, fl, e0, e1, ef} = v;
        cyc = (op[7:5] == 3'h1 && op[3:0] >= 4'h3 && op[3:0] <= 4'h6) ? 6 : 4;
        bus_wr(A_P0, p0, OK);
        bus_wr(A_P1, p1, OK);
        bus_wr(`SSPX_OFS_FLAGS, fl, OK);
        offer({op, a, b});
        wait_flag(1'b0, n);
        wait_flag(1'b1, n);
        // Count starts two edges after the take, so the edge that shows taken is added back
        `CHK("cycles", cyc, n + 1)
        `CHK("flags", ef[5:0], flg)
        bus_rd(A_P0, e0, OK);
        bus_rd(A_P1, e1, OK);
    endtask

    task automatic print_verdict;
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        print_verdict();
    end

    initial begin
        int n;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus_rd(A_P0, 8'h00, OK);
        bus_rd(A_P1, 8'h08, OK);
        bus_rd(`SSPX_OFS_FLAGS, 8'h00, OK);
        bus_rd(12'h010, 8'h00, `SSPX_RESP_SLVERR);
        bus_wr(12'h010, 8'h5A, `SSPX_RESP_SLVERR);
        run(72'h22_67_00_D6_03_20_D3_03_0A);
        `CHK("result", 8'hD3, res)
        run(72'h23_67_00_D6_D6_20_00_D6_12);
        run(72'h24_D7_D6_21_90_20_91_90_2E);
        run(72'h25_D7_D6_65_D7_20_8E_D7_2F);
        run(72'h26_D7_65_00_21_20_00_BC_2B);
        run(72'h32_76_00_D3_10_20_D3_3C_23);
        run(72'h33_76_00_D6_40_20_D6_69_23);
        run(72'h34_D6_D7_03_10_20_03_0C_03);
        run(72'h35_D6_D7_D6_20_00_D6_4A_23);
        run(72'h36_D6_8A_10_00_20_85_00_2F);
        `CHK("result", 8'h85, res)
        run(72'hD0_D7_00_00_9A_27_00_CD_0B);
        `CHK("result", 8'hCD, res)
        run(72'hD1_D6_00_D7_01_14_D7_00_30);
        run(72'hDF_00_00_12_34_1E_12_34_3E);
        run(72'h31_40_40_00_00_15_40_48_15);
        run(72'h31_52_52_00_00_2A_50_00_2A);
        run(72'h31_69_69_00_00_00_00_68_00);
        // Stop, then an offer that must wait until the wake pin releases it
        bus_wr(`SSPX_OFS_FLAGS, 8'h15, OK);
        bus_wr(A_P0, 8'h5A, OK);
        offer({`SSPX_OPC_STOP, 16'h0000});
        wait_flag(1'b0, n);
        offer({`SSPX_OPC_SCF, 16'h0000});
        repeat (30) @(posedge clk_i);
        `CHK("stopped", 1'b1, stopped)
        `CHK("ready", 1'b0, ready)
        `CHK("flags", 6'h15, flg)
        bus_rd(`SSPX_OFS_STATUS, 8'h03, OK);
        wake <= 1'b1;
        wait_flag(1'b0, n);
        wake <= 1'b0;
        `CHK("stopped", 1'b0, stopped)
        wait_flag(1'b1, n);
        `CHK("flags", 6'h35, flg)
        bus_rd(A_P0, 8'h5A, OK);
        // Leaving stop through reset; reset held for two edges, no settling span modelled
        offer({`SSPX_OPC_STOP, 16'h0000});
        wait_flag(1'b0, n);
        repeat (20) @(posedge clk_i);
        `CHK("stopped", 1'b1, stopped)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("stopped", 1'b0, stopped)
        bus_rd(A_P1, 8'h08, OK);
        print_verdict();
    end
endmodule
